// File: dv/lin_transceiver_mode_wake_control_tb.sv
// Self-checking bench for the transceiver mode and wake controller
module lin_transceiver_mode_wake_control_tb
  import lmw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] REC = 3'b001;
  localparam logic [2:0] MID = 3'b100;
  localparam logic [2:0] DOM = 3'b110;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic req = 1'b0;
  logic txdat = 1'b1;
  logic wake = 1'b1;
  logic blow = 1'b0;
  logic bdom = 1'b0;
  logic bhigh = 1'b1;
  logic sup = 1'b0;
  logic hot = 1'b0;
  logic cool = 1'b0;
  logic mode_sel, txd, rxd_pin, txd_pin, txd_oe, weak_pd, rxd_oe, drv, term, rx_en, reg_sw;
  logic txd_lvl, rxd_lvl;
  lmw_mode_t mode;
  logic [7:0] st;
  int n_fail = 0;
  int n_checks = 0;

  // Snapshot: mode, rxd pull, strong pd, weak pd, regulator, termination, driver
  assign st = {mode, rxd_oe, txd_oe, weak_pd, reg_sw, term, drv};
  always #20 clk = ~clk;

  lmw_mode_ctrl #(
    .WAKE_FILT_CYCLES(8),
    .BUS_FILT_CYCLES(8),
    .EN_NOM_CYCLES(4),
    .MON_WINDOW_CYCLES(20),
    .TXD_TIMEOUT_CYCLES(200)
  ) uut (
    .i_core_clk(clk),
    .i_rst_b(rst_b),
    .i_mode_sel(mode_sel),
    .i_txd(txd),
    .o_txd(txd_lvl),
    .o_txd_oe(txd_oe),
    .o_txd_weak_pd(weak_pd),
    .o_rxd(rxd_lvl),
    .o_rxd_oe(rxd_oe),
    .i_wake(wake),
    .i_bus_below_prewake_low_level(blow),
    .i_bus_dominant_level(bdom),
    .i_bus_above_prewake_high_level(bhigh),
    .o_bus_drive_dominant(drv),
    .o_bus_termination_en(term),
    .o_bus_receiver_en(rx_en),
    .i_supply_ok(sup),
    .i_over_temp(hot),
    .i_temp_cooled(cool),
    .o_regulator_switch_out(reg_sw),
    .o_mode(mode)
  );

  lmw_host_model host (
    .i_core_clk(clk),
    .i_req_normal(req),
    .i_tx_data(txdat),
    .i_txd_oe(txd_oe),
    .i_rxd_oe(rxd_oe),
    .o_mode_sel(mode_sel),
    .o_txd(txd),
    .o_rxd_pin(rxd_pin),
    .o_txd_pin(txd_pin)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      n_fail++;
  endtask

  // Bounded wait, then room for the transmit sync lag to settle
  task automatic wait_mode(input lmw_mode_t m);
    int k;
    k = 0;
    while (mode !== m && k < 80)
    begin
      cyc(1);
      k++;
    end
    cyc(4);
  endtask

  task automatic bus(input logic [2:0] v);
    {blow, bdom, bhigh} = v;
  endtask

  task automatic go_normal();
    req = 1'b1;
    wait_mode(LMW_NORMAL);
    chk(st, 8'h46);
  endtask

  task automatic go_sleep();
    txdat = 1'b1;
    req = 1'b0;
    wait_mode(LMW_SLEEP);
    chk(st, 8'hC0);
  endtask

  task automatic t_power();
    cyc(5);
    chk(st, 8'h02);
    sup = 1'b1;
    cyc(5);
    chk(st, 8'h06);
    chk({6'h00, rxd_lvl, txd_lvl}, 8'h00);
    $display("power-up test done");
  endtask

  task automatic t_normal();
    go_normal();
    txdat = 1'b0;
    cyc(5);
    chk(st, 8'h47);
    bus(DOM);
    cyc(5);
    chk({7'h00, rxd_pin}, 8'h00);
    bus(REC);
    txdat = 1'b1;
    cyc(5);
    chk({7'h00, rxd_pin}, 8'h01);
    $display("normal mode test done");
  endtask

  task automatic t_thermal();
    txdat = 1'b0;
    hot = 1'b1;
    cyc(5);
    chk(st, 8'h46);
    hot = 1'b0;
    cyc(5);
    chk(st, 8'h46);
    cool = 1'b1;
    cyc(5);
    chk(st, 8'h47);
    cool = 1'b0;
    txdat = 1'b1;
    cyc(5);
    $display("thermal test done");
  endtask

  task automatic t_timeout();
    txdat = 1'b0;
    cyc(210);
    chk(st, 8'h46);
    txdat = 1'b1;
    cyc(100);
    txdat = 1'b0;
    cyc(5);
    chk(st, 8'h46);
    txdat = 1'b1;
    cyc(260);
    txdat = 1'b0;
    cyc(5);
    chk(st, 8'h47);
    txdat = 1'b1;
    cyc(5);
    $display("transmit timeout test done");
  endtask

  task automatic t_remote();
    go_sleep();
    bus(DOM);
    cyc(3);
    bus(REC);
    cyc(80);
    chk(st, 8'hC0);
    bus(DOM);
    cyc(4);
    chk({7'h00, rx_en}, 8'h01);
    cyc(10);
    bus(REC);
    wait_mode(LMW_FAILSAFE);
    chk(st, 8'h2E);
    chk({6'h00, rxd_pin, txd_pin}, 8'h01);
    go_normal();
    $display("remote wake test done");
  endtask

  task automatic t_window();
    go_sleep();
    bus(MID);
    cyc(4);
    chk({7'h00, rx_en}, 8'h01);
    cyc(30);
    chk({5'h00, rx_en, mode}, 8'h03);
    bus(REC);
    cyc(10);
    bus(DOM);
    cyc(14);
    bus(REC);
    cyc(10);
    chk(st, 8'hC0);
    cyc(60);
    bus(DOM);
    cyc(14);
    bus(REC);
    wait_mode(LMW_FAILSAFE);
    chk(st, 8'h2E);
    go_normal();
    $display("monitor window test done");
  endtask

  task automatic t_stuck();
    go_sleep();
    bus(DOM);
    cyc(60);
    chk({5'h00, rx_en, mode}, 8'h03);
    bus(REC);
    wait_mode(LMW_FAILSAFE);
    chk(st, 8'h2E);
    go_normal();
    $display("stuck dominant test done");
  endtask

  task automatic t_local();
    wake = 1'b0;
    cyc(20);
    go_sleep();
    cyc(40);
    chk(st, 8'hC0);
    wake = 1'b1;
    cyc(160);
    wake = 1'b0;
    cyc(3);
    wake = 1'b1;
    cyc(20);
    chk(st, 8'hC0);
    wake = 1'b0;
    wait_mode(LMW_FAILSAFE);
    chk(st, 8'h36);
    chk({6'h00, rxd_pin, txd_pin}, 8'h00);
    wake = 1'b1;
    go_normal();
    $display("local wake test done");
  endtask

  // Supply loss wakes without flags; regulator stays off until supply returns
  task automatic t_supply();
    go_sleep();
    sup = 1'b0;
    wait_mode(LMW_FAILSAFE);
    chk(st, 8'h02);
    sup = 1'b1;
    cyc(5);
    chk(st, 8'h06);
    $display("supply loss test done");
  endtask

  task automatic close_out();
    $display("Checks: %0d, failures: %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    cyc(2);
    rst_b = 1'b1;
    t_power();
    t_normal();
    t_thermal();
    t_timeout();
    t_remote();
    t_window();
    t_stuck();
    t_local();
    t_supply();
    close_out();
  end

  // About seven times the expected run length
  initial
  begin
    #(10000 * 40);
    n_fail++;
    close_out();
  end
endmodule

// File: dv/lmw_host_model.sv
// Host controller model: drives mode-select and transmit, reads the wake pins
module lmw_host_model
(
  // Clock
  input wire logic i_core_clk,
  // Commands from the bench
  input wire logic i_req_normal,
  input wire logic i_tx_data,
  // Device pin controls
  input wire logic i_txd_oe,
  input wire logic i_rxd_oe,
  // Pin levels
  output logic o_mode_sel,
  output logic o_txd,
  output logic o_rxd_pin,
  output logic o_txd_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tx_q;
  logic req_s;
  logic dat_s;

  initial
  begin
    tx_q = 1'b1;
    o_mode_sel = 1'b0;
  end

  // Mode-select drops only once transmit has already been high for a cycle
  // Commands taken at the edge, so the bench's own update cannot race them
  always @(posedge i_core_clk)
  begin
    req_s = i_req_normal;
    dat_s = i_tx_data;
    #1;
    o_mode_sel = req_s | (o_mode_sel & ~tx_q);
    tx_q = req_s ? dat_s : 1'b1;
  end

  // Strong pull-down beats the host; weak one loses to the 5k pull-up
  assign o_txd = tx_q & ~i_txd_oe;
  assign o_txd_pin = ~i_txd_oe;
  assign o_rxd_pin = ~i_rxd_oe;
endmodule

// File: src/lmw_debounce.sv
// Level debouncer with separate rise and fall acceptance times
module lmw_debounce
  import lmw_pkg::*;
#(
  parameter int HIGH_CYCLES = 1,
  parameter int LOW_CYCLES = 1,
  parameter logic INIT = 1'b0
)
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Level in and filtered level out
  input wire logic i_level,
  output logic o_level
);

  localparam int MAXC = (HIGH_CYCLES > LOW_CYCLES) ? HIGH_CYCLES : LOW_CYCLES;
  localparam int CW = $clog2(MAXC + 1);

  logic lvl_q;
  logic lvl_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] need;

  // Any glitch back to the held level restarts the count
  always_comb
  begin
    need = i_level ? CW'(HIGH_CYCLES - 1) : CW'(LOW_CYCLES - 1);
    lvl_d = lvl_q;
    cnt_d = '0;
    if (i_level != lvl_q)
    begin
      if (cnt_q >= need)
        lvl_d = i_level;
      else
        cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lvl_q <= INIT;
      cnt_q <= '0;
    end
    else
    begin
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_level = lvl_q;

endmodule

// File: src/lmw_mode_ctrl.sv
// Mode, wake detection and pin control of a bus transceiver
// Overview of operation
// [RULE_01] Sleep keeps the transmit path off; bus or local wake moves to fail-safe.
// [RULE_02] Fail-safe goes to normal when filtered mode-select is high.
// [RULE_03] Local wake, bus wake and mode-select each have their own filter timer.
// [RULE_04] Sleep turns regulator switch and bus termination off.
// [RULE_05] Sleep entry ignores the bus and local wake levels.
// [RULE_06] Reset and wakes enter fail-safe; regulator switch on when supply is good.
// [RULE_07] Pin behaviour per mode: receive high, bus-following, or released.
// [RULE_08] Bus fall, dominant held for bus filter, then rise gives remote wake.
// [RULE_09] Pending remote wake pulls the receive output low.
// [RULE_10] Bus below pre-wake low in sleep enables receiver and starts window.
// [RULE_11] Receiver stays on only for the window; timeout returns to quiet sleep.
// [RULE_12] Dominant beyond the window stays asleep; the next rise wakes directly.
// [RULE_13] After a timeout, bus must stay above pre-wake high before re-arming.
// [RULE_14] Local wake fall then low for local filter gives local wake.
// [RULE_15] Local wake pulls receive low and strongly pulls transmit low.
// [RULE_16] Continuous local low never blocks sleep; re-arm needs over 6 us high.
// [RULE_17] Fail-safe shows wake source: weak pull-down remote, strong local.
// [RULE_18] Both wake indications clear at once when mode-select goes high.
// [RULE_19] Over-temperature turns the bus driver off until cooled by hysteresis.
// [RULE_20] Sleep allowed during a bus short to ground; short ending wakes remotely.
// [RULE_21] Unconnected mode-select and transmit read as low.
// [RULE_22] Sleep entered on mode-select fall only while transmit is high.
// [RULE_23] Timeout variant: transmit low over 40 ms forces recessive until high 10 us.
// [RULE_24] Filter and window durations are cycle-count parameters.
module lmw_mode_ctrl
  import lmw_pkg::*;
#(
  parameter int WAKE_FILT_CYCLES = WAKE_FILT_CYCLES_DEF,
  parameter int BUS_FILT_CYCLES = BUS_FILT_CYCLES_DEF,
  parameter int EN_SLEEP_CYCLES = EN_SLEEP_CYCLES_DEF,
  parameter int EN_NOM_CYCLES = EN_NOM_CYCLES_DEF,
  parameter int MON_WINDOW_CYCLES = MON_WINDOW_CYCLES_DEF,
  parameter int TXD_TIMEOUT_CYCLES = TXD_DOM_CYCLES,
  parameter bit TXD_TIMEOUT_EN = 1'b1
)
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // Host side pins
  input wire logic i_mode_sel,
  input wire logic i_txd,
  output logic o_txd,
  output logic o_txd_oe,
  output logic o_txd_weak_pd,
  output logic o_rxd,
  output logic o_rxd_oe,
  // Local wake pin
  input wire logic i_wake,
  // Bus comparators and bus controls
  input wire logic i_bus_below_prewake_low_level,
  input wire logic i_bus_dominant_level,
  input wire logic i_bus_above_prewake_high_level,
  output logic o_bus_drive_dominant,
  output logic o_bus_termination_en,
  output logic o_bus_receiver_en,
  // Supply and temperature monitors
  input wire logic i_supply_ok,
  input wire logic i_over_temp,
  input wire logic i_temp_cooled,
  output logic o_regulator_switch_out,
  // Status
  output lmw_mode_t o_mode
);

  localparam int MW = $clog2(MON_WINDOW_CYCLES + 1);
  localparam int PW = $clog2(PREWAKE_HIGH_CYCLES + 1);
  localparam int RW = $clog2(WAKE_REARM_CYCLES + 1);
  localparam int TW = $clog2(TXD_TIMEOUT_CYCLES + 1);
  localparam int HW = $clog2(TXD_REL_CYCLES + 1);

  // Pin synchronisers; stage one feeds stage two only
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic txd_s;
  logic wake_s;
  logic bus_low_s;
  logic bus_dom_s;
  logic bus_high_s;
  logic supply_s;
  logic hot_s;
  logic cool_s;

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sync1_q <= SYNC_RST; // RULE_21
      sync2_q <= SYNC_RST;
    end
    else
    begin
      sync1_q <= {i_temp_cooled, i_over_temp, i_supply_ok, i_bus_above_prewake_high_level,
                  i_bus_dominant_level, i_bus_below_prewake_low_level, i_wake, i_txd,
                  i_mode_sel};
      sync2_q <= sync1_q;
    end
  end

  assign txd_s = sync2_q[SYNC_TXD];
  assign wake_s = sync2_q[SYNC_WAKE];
  assign bus_low_s = sync2_q[SYNC_BUS_LOW];
  assign bus_dom_s = sync2_q[SYNC_BUS_DOM];
  assign bus_high_s = sync2_q[SYNC_BUS_HIGH];
  assign supply_s = sync2_q[SYNC_SUPPLY];
  assign hot_s = sync2_q[SYNC_HOT];
  assign cool_s = sync2_q[SYNC_COOL];

  // Separate filters for mode-select, local wake and bus dominant
  logic en_f;
  logic wake_f;
  logic dom_f;

  lmw_debounce #(.HIGH_CYCLES(EN_NOM_CYCLES), .LOW_CYCLES(EN_SLEEP_CYCLES), .INIT(1'b0))
  u_en_filt // RULE_03 RULE_24
  (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_level(sync2_q[SYNC_EN]),
    .o_level(en_f)
  );

  lmw_debounce #(.HIGH_CYCLES(1), .LOW_CYCLES(WAKE_FILT_CYCLES), .INIT(1'b1))
  u_wake_filt // RULE_03 RULE_24
  (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_level(wake_s),
    .o_level(wake_f)
  );

  lmw_debounce #(.HIGH_CYCLES(BUS_FILT_CYCLES), .LOW_CYCLES(1), .INIT(1'b0))
  u_bus_filt // RULE_03 RULE_24
  (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_level(bus_dom_s),
    .o_level(dom_f)
  );

  logic en_prev_q;
  logic wake_prev_q;
  logic en_fall;
  logic wake_fall;

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      en_prev_q <= 1'b0;
      wake_prev_q <= 1'b1;
    end
    else
    begin
      en_prev_q <= en_f;
      wake_prev_q <= wake_f;
    end
  end

  assign en_fall = en_prev_q && !en_f;
  assign wake_fall = wake_prev_q && !wake_f;

  // Local wake arming
  logic armed_q;
  logic armed_d;
  logic [RW-1:0] rearm_cnt_q;
  logic [RW-1:0] rearm_cnt_d;

  always_comb
  begin
    armed_d = armed_q;
    rearm_cnt_d = '0;
    if (wake_s)
    begin
      if (rearm_cnt_q >= RW'(WAKE_REARM_CYCLES))
        armed_d = 1'b1; // RULE_16
      else
        rearm_cnt_d = rearm_cnt_q + RW'(1);
    end
    // Held-low switch disarms, so it cannot block or re-trigger sleep
    if (wake_fall)
      armed_d = 1'b0; // RULE_16
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      armed_q <= 1'b0;
      rearm_cnt_q <= '0;
    end
    else
    begin
      armed_q <= armed_d;
      rearm_cnt_q <= rearm_cnt_d;
    end
  end

  // Pre-wake monitoring in sleep
  lmw_mode_t mode_q;
  lmw_mode_t mode_d;
  lmw_pw_t pw_q;
  lmw_pw_t pw_d;
  logic [MW-1:0] mon_cnt_q;
  logic [MW-1:0] mon_cnt_d;
  logic [PW-1:0] lock_cnt_q;
  logic [PW-1:0] lock_cnt_d;
  logic mon_end;

  assign mon_end = mon_cnt_q >= MW'(MON_WINDOW_CYCLES - 1);

  always_comb
  begin
    pw_d = pw_q;
    mon_cnt_d = '0;
    lock_cnt_d = '0;
    if (mode_q != LMW_SLEEP)
      pw_d = LMW_PW_IDLE;
    else
    begin
      unique case (pw_q)
        LMW_PW_IDLE:
          if (bus_low_s)
            pw_d = LMW_PW_MON; // RULE_10
        LMW_PW_MON:
        begin
          mon_cnt_d = mon_cnt_q + MW'(1);
          if (dom_f)
            pw_d = LMW_PW_DOM; // RULE_08
          else if (mon_end)
            pw_d = LMW_PW_LOCK; // RULE_11
        end
        LMW_PW_DOM:
        begin
          mon_cnt_d = mon_cnt_q + MW'(1);
          if (!bus_dom_s)
            pw_d = LMW_PW_IDLE; // RULE_08
          else if (mon_end)
            pw_d = LMW_PW_STUCK; // RULE_12
        end
        LMW_PW_STUCK:
          if (bus_high_s)
            pw_d = LMW_PW_IDLE; // RULE_12 RULE_20
        LMW_PW_LOCK:
          if (bus_high_s)
          begin
            lock_cnt_d = lock_cnt_q + PW'(1);
            if (lock_cnt_q >= PW'(PREWAKE_HIGH_CYCLES - 1))
              pw_d = LMW_PW_IDLE; // RULE_13
          end
        default:
          pw_d = LMW_PW_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pw_q <= LMW_PW_IDLE;
      mon_cnt_q <= '0;
      lock_cnt_q <= '0;
    end
    else
    begin
      pw_q <= pw_d;
      mon_cnt_q <= mon_cnt_d;
      lock_cnt_q <= lock_cnt_d;
    end
  end

  // Mode machine and wake flags
  logic rflag_q;
  logic rflag_d;
  logic lflag_q;
  logic lflag_d;
  logic remote_req;
  logic local_req;

  assign remote_req = (mode_q == LMW_SLEEP) && (((pw_q == LMW_PW_DOM) && !bus_dom_s)
                      || ((pw_q == LMW_PW_STUCK) && bus_high_s)); // RULE_08 RULE_12
  assign local_req = (mode_q == LMW_SLEEP) && armed_q && wake_fall; // RULE_14

  always_comb
  begin
    mode_d = mode_q;
    rflag_d = rflag_q;
    lflag_d = lflag_q;
    unique case (mode_q)
      LMW_FAILSAFE:
        if (en_f)
        begin
          mode_d = LMW_NORMAL; // RULE_02
          rflag_d = 1'b0; // RULE_18
          lflag_d = 1'b0; // RULE_18
        end
      LMW_NORMAL:
        // Level on bus or wake pin is not consulted here
        if (en_fall && txd_s)
          mode_d = LMW_SLEEP; // RULE_22 RULE_05
      LMW_SLEEP:
      begin
        if (remote_req || local_req || !supply_s)
          mode_d = LMW_FAILSAFE; // RULE_01 RULE_06
        if (remote_req)
          rflag_d = 1'b1; // RULE_09
        if (local_req)
          lflag_d = 1'b1; // RULE_15
      end
      default:
        mode_d = LMW_FAILSAFE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      mode_q <= LMW_FAILSAFE; // RULE_06
      rflag_q <= 1'b0;
      lflag_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      rflag_q <= rflag_d;
      lflag_q <= lflag_d;
    end
  end

  // Transmit timeout and thermal shutdown
  logic tmo_q;
  logic tmo_d;
  logic hot_q;
  logic hot_d;
  logic [TW-1:0] lo_cnt_q;
  logic [TW-1:0] lo_cnt_d;
  logic [HW-1:0] hi_cnt_q;
  logic [HW-1:0] hi_cnt_d;

  always_comb
  begin
    tmo_d = tmo_q;
    lo_cnt_d = '0;
    hi_cnt_d = '0;
    if (!txd_s)
    begin
      if (lo_cnt_q >= TW'(TXD_TIMEOUT_CYCLES))
        tmo_d = TXD_TIMEOUT_EN; // RULE_23
      else
        lo_cnt_d = lo_cnt_q + TW'(1);
    end
    else if (hi_cnt_q >= HW'(TXD_REL_CYCLES))
      tmo_d = 1'b0; // RULE_23
    else
      hi_cnt_d = hi_cnt_q + HW'(1);
    // Set wins: a fresh over-temperature beats a cool report in the same cycle
    hot_d = hot_s || (hot_q && !cool_s); // RULE_19
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      tmo_q <= 1'b0;
      hot_q <= 1'b0;
      lo_cnt_q <= '0;
      hi_cnt_q <= '0;
    end
    else
    begin
      tmo_q <= tmo_d;
      hot_q <= hot_d;
      lo_cnt_q <= lo_cnt_d;
      hi_cnt_q <= hi_cnt_d;
    end
  end

  // Registered pin controls, computed from next state so they align with mode_q
  logic drv_d;
  logic term_d;
  logic rx_en_d;
  logic rxd_oe_d;
  logic txd_oe_d;
  logic txd_wpd_d;
  logic reg_sw_d;

  always_comb
  begin
    drv_d = (mode_d == LMW_NORMAL) && !txd_s && !tmo_d && !hot_d; // RULE_01 RULE_07 RULE_19
    term_d = (mode_d != LMW_SLEEP); // RULE_04
    reg_sw_d = (mode_d != LMW_SLEEP) && supply_s; // RULE_04 RULE_06
    rx_en_d = (pw_d == LMW_PW_MON) || (pw_d == LMW_PW_DOM); // RULE_10 RULE_11
    txd_oe_d = (mode_d == LMW_FAILSAFE) && lflag_d; // RULE_15 RULE_17
    txd_wpd_d = (mode_d == LMW_FAILSAFE) && rflag_d && !lflag_d; // RULE_17
    unique case (mode_d)
      LMW_NORMAL:
        rxd_oe_d = bus_dom_s; // RULE_07
      LMW_FAILSAFE:
        rxd_oe_d = rflag_d || lflag_d; // RULE_09 RULE_15
      default:
        rxd_oe_d = 1'b0; // RULE_07
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_bus_drive_dominant <= 1'b0;
      o_bus_termination_en <= 1'b1;
      o_regulator_switch_out <= 1'b0;
      o_bus_receiver_en <= 1'b0;
      o_rxd_oe <= 1'b0;
      o_txd_oe <= 1'b0;
      o_txd_weak_pd <= 1'b0;
    end
    else
    begin
      o_bus_drive_dominant <= drv_d;
      o_bus_termination_en <= term_d;
      o_regulator_switch_out <= reg_sw_d;
      o_bus_receiver_en <= rx_en_d;
      o_rxd_oe <= rxd_oe_d;
      o_txd_oe <= txd_oe_d;
      o_txd_weak_pd <= txd_wpd_d;
    end
  end

  // Open-drain pins only ever pull low
  assign o_rxd = 1'b0;
  assign o_txd = 1'b0;
  assign o_mode = mode_q;

  // Checks
  sequence s_remote_seen;
    (mode_q == LMW_SLEEP) && (pw_q == LMW_PW_DOM) && !bus_dom_s;
  endsequence

  sequence s_failsafe_remote;
    (mode_q == LMW_FAILSAFE) && o_rxd_oe && o_txd_weak_pd && o_regulator_switch_out == supply_s;
  endsequence

  a_sleep_tx_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE_01
    (mode_q == LMW_SLEEP) |-> !o_bus_drive_dominant)
    else $error("bus driven in sleep");

  a_failsafe_normal: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE_02
    (mode_q == LMW_FAILSAFE) && en_f |=> (mode_q == LMW_NORMAL))
    else $error("no normal entry from fail-safe");

  a_sleep_outputs: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE_04
    (mode_q == LMW_SLEEP) |-> !o_regulator_switch_out && !o_bus_termination_en && !o_rxd_oe)
    else $error("sleep outputs wrong");

  a_remote_wake: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE_08
    s_remote_seen |=> s_failsafe_remote)
    else $error("remote wake not taken");

  a_rx_window: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE_11
    (pw_q == LMW_PW_MON) && !dom_f && mon_end |=> !o_bus_receiver_en ##1 (pw_q == LMW_PW_LOCK))
    else $error("receiver window overrun");

  a_local_wake: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE_14
    local_req |=> (mode_q == LMW_FAILSAFE) && o_txd_oe && o_rxd_oe && !o_txd_weak_pd)
    else $error("local wake not signalled");

  a_flags_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE_18
    (mode_q == LMW_FAILSAFE) && en_f |=> !o_txd_oe && !o_txd_weak_pd && !rflag_q && !lflag_q)
    else $error("wake flags not cleared");

  a_sleep_entry: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE_22
    (mode_q == LMW_NORMAL) && en_fall |=> (mode_q == ($past(txd_s) ? LMW_SLEEP : LMW_NORMAL)))
    else $error("sleep entry wrong");

  a_thermal_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE_19
    hot_s |=> !o_bus_drive_dominant [*2])
    else $error("driver on while hot");

  a_tx_timeout: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE_23
    tmo_q && !txd_s |=> tmo_q && !o_bus_drive_dominant)
    else $error("timeout released while low");

endmodule

// File: src/lmw_pkg.sv
// Shared constants and types for the transceiver mode and wake controller
package lmw_pkg;

  // Core clock period
  localparam int CLK_PERIOD_NS = 40;

  // Local wake re-arm: input high for more than this before a new wake
  localparam int WAKE_REARM_NS = 6000;
  localparam int WAKE_REARM_CYCLES = (WAKE_REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus must sit above the pre-wake high level this long after a timed-out pre-wake
  localparam int PREWAKE_HIGH_NS = 2000;
  localparam int PREWAKE_HIGH_CYCLES = (PREWAKE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Transmit dominant timeout and its release time
  localparam int TXD_DOM_MS = 40;
  localparam int TXD_DOM_CYCLES = (TXD_DOM_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TXD_REL_NS = 10000;
  localparam int TXD_REL_CYCLES = (TXD_REL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Default filter and window counts in core cycles
  localparam int WAKE_FILT_CYCLES_DEF = 64;
  localparam int BUS_FILT_CYCLES_DEF = 64;
  localparam int EN_SLEEP_CYCLES_DEF = 16;
  localparam int EN_NOM_CYCLES_DEF = 16;
  localparam int MON_WINDOW_CYCLES_DEF = 256;

  // Synchroniser bit positions
  localparam int SYNC_W = 9;
  localparam int SYNC_EN = 0;
  localparam int SYNC_TXD = 1;
  localparam int SYNC_WAKE = 2;
  localparam int SYNC_BUS_LOW = 3;
  localparam int SYNC_BUS_DOM = 4;
  localparam int SYNC_BUS_HIGH = 5;
  localparam int SYNC_SUPPLY = 6;
  localparam int SYNC_HOT = 7;
  localparam int SYNC_COOL = 8;
  // Mode select and transmit read low, wake reads high (idle), bus reads recessive
  localparam logic [SYNC_W-1:0] SYNC_RST = 9'h024;

  typedef enum logic [1:0]
  {
    LMW_FAILSAFE = 2'b00,
    LMW_NORMAL = 2'b01,
    LMW_SLEEP = 2'b11
  } lmw_mode_t;

  typedef enum logic [2:0]
  {
    LMW_PW_IDLE = 3'b000,
    LMW_PW_MON = 3'b001,
    LMW_PW_DOM = 3'b011,
    LMW_PW_STUCK = 3'b010,
    LMW_PW_LOCK = 3'b110
  } lmw_pw_t;

endpackage
